// *** ipe_pkg.sv ***
// Notes on behaviour
// [RL1] The master writes a one to every pin it uses as an input, so only outside drivers set it.
// [RL2] A read returns the outside level on input pins and the last written level on output pins.
// [RL3] A change on the port pins is signalled on the alert output without any bus traffic.
// [RL4] Pins of one octet tied together for more sink current are always switched together.
// [RL5] Each complete written byte is stored into its octet register in the acknowledge slot; the code queues it and applies it once pins settle.
// [RL6] Written bytes go to the low port first, then the high port, alternating until a stop.
// [RL7] Every write refreshes both read snapshots and clears all pending alerts.
// [RL8] At the start of each read byte the current levels of the octet to be sent are loaded.
// [RL9] Read bytes carry the low port first, then the high port, alternating until a stop.
// [RL10] Reading the low byte clears only the low-port alert.
// [RL11] Reading the high byte clears only the high-port alert.
// [RL12] Address bit 0 picks the direction: zero writes the ports, one reads them.
// [RL13] Any rising or falling edge on a port pin raises the alert; edges while a port update settles are ignored.
// [RL14] An alert is withdrawn when the pins return to their captured value.
// [RL15] Reset clears the serial logic and releases every pin to the weak-high input state.
// [RL16] Each octet keeps its own pending flag and the active-low alert shows either one.
package ipe_pkg;

    // ----------------------------------------
    // Serial slave states
    // ----------------------------------------
    typedef enum logic [2:0] {
        IPE_IDLE     = 3'h0,
        IPE_ADDR     = 3'h1,
        IPE_ADDR_ACK = 3'h3,
        IPE_WR_DATA  = 3'h2,
        IPE_WR_ACK   = 3'h6,
        IPE_RD_DATA  = 3'h7,
        IPE_RD_ACK   = 3'h5
    } ipe_state_t;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [3:0] ADDR_FIXED_RST = 4'h4;   // Arbitrary upper address bits
    localparam int ADDR_RW_POS = 0;
    localparam int OCTET_W = 8;
    localparam int PORT_W = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_RD_FALL = 4'h7;
    localparam logic [7:0] PINS_OUT_VAL = 8'h00;    // Pins only ever pull low
    localparam logic [7:0] DRIVE_RST = 8'h00;       // Released, weak high
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int FIFO_W = OCTET_W + 1;            // Octet select above the data
    localparam int FIFO_SEL_POS = 8;
    localparam int SETTLE_W = 16;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PORT_VALID_NS = 4000;            // Output valid time, longest
    localparam int SETTLE_CYC = (PORT_VALID_NS / CLK_PERIOD_NS < 1) ? 1 :
                                PORT_VALID_NS / CLK_PERIOD_NS;

endpackage : ipe_pkg

// *** ipe_fifo.sv ***
`timescale 1ns/1ps
module ipe_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    // Pointer wrap relies on a power-of-two depth
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("ipe_fifo needs a power-of-two depth of two or more");
        end
    endgenerate

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic do_wr;
    logic do_rd;

    // ----------------------------------------
    // Flags and handshakes
    // ----------------------------------------
    // Extra pointer bit tells full from empty
    assign in_ready = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // Pointers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_wr) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (do_rd) rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (do_wr) mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end

endmodule : ipe_fifo

// *** ipe_port_expander.sv ***
`timescale 1ns/1ps
module ipe_port_expander
    import ipe_pkg::*;
#(
    parameter logic [3:0] FIXED_ADDR = ipe_pkg::ADDR_FIXED_RST,
    parameter int FIFO_DEPTH = ipe_pkg::FIFO_DEPTH_DEF,
    parameter int SETTLE_CYCLES = ipe_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] addr_pins_i,
    input wire logic [7:0] low_port_pins_i,
    output logic [7:0] low_port_pins_o,
    output logic [7:0] low_port_pins_oe,
    input wire logic [7:0] high_port_pins_i,
    output logic [7:0] high_port_pins_o,
    output logic [7:0] high_port_pins_oe,
    output logic alert_n
);
    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << ipe_pkg::SETTLE_W)) begin : g_bad
            $error("SETTLE_CYCLES out of range for the settle counter");
        end
    endgenerate

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    logic [2:0] addr_m_ff;
    logic [2:0] addr_s_ff;
    logic [7:0] lo_m_ff;
    logic [7:0] lo_s_ff;
    logic [7:0] hi_m_ff;
    logic [7:0] hi_s_ff;
    ipe_state_t state_ff;
    logic [3:0] bitcnt_ff;
    logic [7:0] shift_ff;
    logic sel_ff;
    logic sda_oe_ff;
    logic push_ff;
    logic [FIFO_W-1:0] push_data_ff;
    logic rd_clr_lo_ff;
    logic rd_clr_hi_ff;
    logic [7:0] drive_lo_ff;
    logic [7:0] drive_hi_ff;
    logic [SETTLE_W-1:0] settle_ff;
    logic [7:0] ref_lo_ff;
    logic [7:0] ref_hi_ff;
    logic pend_lo_ff;
    logic pend_hi_ff;
    logic alert_n_ff;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;
    logic apply;
    logic [7:0] octet_now;

    // Octet picked by the alternating select
    function automatic logic [7:0] pick_octet(input logic sel, input logic [7:0] lo,
                                              input logic [7:0] hi);
        pick_octet = sel ? hi : lo;
    endfunction : pick_octet

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins and the serial clock are asynchronous to clk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            addr_m_ff <= 3'h0;
            addr_s_ff <= 3'h0;
            lo_m_ff <= 8'hFF;
            lo_s_ff <= 8'hFF;
            hi_m_ff <= 8'hFF;
            hi_s_ff <= 8'hFF;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            addr_m_ff <= addr_pins_i;
            addr_s_ff <= addr_m_ff;
            lo_m_ff <= low_port_pins_i;
            lo_s_ff <= lo_m_ff;
            hi_m_ff <= high_port_pins_i;
            hi_s_ff <= hi_m_ff;
        end
    end

    // Edges and bus conditions on the synchronised lines
    assign scl_s = scl_sync_ff[1];
    assign sda_s = sda_sync_ff[1];
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    // Outside level on inputs, own low on driven outputs [RL2]
    assign octet_now = pick_octet(sel_ff, lo_s_ff, hi_s_ff);

    // ----------------------------------------
    // Serial slave
    // ----------------------------------------
    // Stop or start aborts any byte; the sequencer restarts on the low port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= IPE_IDLE;                                   // [RL15]
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            sel_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            push_ff <= 1'b0;
            push_data_ff <= '0;
            rd_clr_lo_ff <= 1'b0;
            rd_clr_hi_ff <= 1'b0;
        end else begin
            push_ff <= 1'b0;
            rd_clr_lo_ff <= 1'b0;
            rd_clr_hi_ff <= 1'b0;
            if (bus_start) begin
                state_ff <= IPE_ADDR;
                bitcnt_ff <= 4'h0;
                sel_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
            end else if (bus_stop) begin
                state_ff <= IPE_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    IPE_ADDR, IPE_WR_DATA: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end else if (scl_fall && bitcnt_ff == BYTE_BITS) begin
                            bitcnt_ff <= 4'h0;
                            if (state_ff == IPE_ADDR) begin
                                if (shift_ff[7:1] == {FIXED_ADDR, addr_s_ff}) begin
                                    state_ff <= IPE_ADDR_ACK;
                                    sda_oe_ff <= 1'b1;
                                end else begin
                                    state_ff <= IPE_IDLE;
                                end
                            end else begin
                                // Stored at the ack slot, master ack or not [RL5]
                                push_ff <= 1'b1;
                                push_data_ff <= {sel_ff, shift_ff};
                                sel_ff <= ~sel_ff;                  // [RL6]
                                // A full queue drops the byte and answers not-ack
                                sda_oe_ff <= fifo_in_ready;
                                state_ff <= IPE_WR_ACK;
                            end
                        end
                    end
                    IPE_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (shift_ff[ADDR_RW_POS]) begin            // [RL12]
                                // Snapshot the octet to send [RL8] [RL9]
                                shift_ff <= octet_now;
                                sda_oe_ff <= ~octet_now[7];
                                rd_clr_lo_ff <= ~sel_ff;            // [RL10]
                                rd_clr_hi_ff <= sel_ff;             // [RL11]
                                sel_ff <= ~sel_ff;
                                state_ff <= IPE_RD_DATA;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= IPE_WR_DATA;
                            end
                        end
                    end
                    IPE_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            state_ff <= IPE_WR_DATA;
                        end
                    end
                    IPE_RD_DATA: begin
                        if (scl_fall) begin
                            if (bitcnt_ff == LAST_RD_FALL) begin
                                bitcnt_ff <= 4'h0;
                                sda_oe_ff <= 1'b0;
                                state_ff <= IPE_RD_ACK;
                            end else begin
                                bitcnt_ff <= bitcnt_ff + 4'h1;
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                sda_oe_ff <= ~shift_ff[6];
                            end
                        end
                    end
                    IPE_RD_ACK: begin
                        // Master ack low asks for the next octet
                        if (scl_rise && sda_s) begin
                            state_ff <= IPE_IDLE;
                        end else if (scl_fall) begin
                            shift_ff <= octet_now;                  // [RL8]
                            sda_oe_ff <= ~octet_now[7];
                            rd_clr_lo_ff <= ~sel_ff;                // [RL10]
                            rd_clr_hi_ff <= sel_ff;                 // [RL11]
                            sel_ff <= ~sel_ff;                      // [RL9]
                            state_ff <= IPE_RD_DATA;
                        end
                    end
                    default: begin
                        state_ff <= IPE_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Write queue
    // ----------------------------------------
    ipe_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push_ff),
        .in_ready(fifo_in_ready),
        .in_data(push_data_ff),
        .out_valid(fifo_out_valid),
        .out_ready(apply),
        .out_data(fifo_out_data)
    );

    // Drain stalls until the pins settle from the last update
    assign apply = fifo_out_valid && settle_ff == '0;

    // ----------------------------------------
    // Port latches
    // ----------------------------------------
    // A one releases the pin; the master keeps inputs and tied groups consistent [RL1] [RL4]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_lo_ff <= DRIVE_RST;                               // [RL15]
            drive_hi_ff <= DRIVE_RST;
            settle_ff <= '0;
        end else if (apply) begin
            if (fifo_out_data[FIFO_SEL_POS]) begin
                drive_hi_ff <= ~fifo_out_data[7:0];
            end else begin
                drive_lo_ff <= ~fifo_out_data[7:0];
            end
            settle_ff <= SETTLE_W'(SETTLE_CYCLES);
        end else if (settle_ff != '0) begin
            settle_ff <= settle_ff - 1'b1;
        end
    end

    // ----------------------------------------
    // Change alert
    // ----------------------------------------
    // Own output changes would look like input edges, so track pins while settling
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_lo_ff <= 8'hFF;
            ref_hi_ff <= 8'hFF;
            pend_lo_ff <= 1'b0;
            pend_hi_ff <= 1'b0;
        end else if (apply || settle_ff != '0) begin
            ref_lo_ff <= lo_s_ff;                                   // [RL7]
            ref_hi_ff <= hi_s_ff;
            pend_lo_ff <= 1'b0;
            pend_hi_ff <= 1'b0;
        end else begin
            // Compare to the captured value: edges set, a return clears [RL13] [RL14]
            // Reference is the octet just sent, so an edge right after the load still sets
            if (rd_clr_lo_ff) ref_lo_ff <= shift_ff;                // [RL10]
            if (rd_clr_hi_ff) ref_hi_ff <= shift_ff;                // [RL11]
            pend_lo_ff <= lo_s_ff != (rd_clr_lo_ff ? shift_ff : ref_lo_ff);  // [RL16]
            pend_hi_ff <= hi_s_ff != (rd_clr_hi_ff ? shift_ff : ref_hi_ff);
        end
    end

    // Active-low alert, no bus access needed [RL3]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_n_ff <= 1'b1;
        end else begin
            alert_n_ff <= ~(pend_lo_ff | pend_hi_ff);               // [RL16]
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign low_port_pins_o = PINS_OUT_VAL;
    assign high_port_pins_o = PINS_OUT_VAL;
    assign low_port_pins_oe = drive_lo_ff;
    assign high_port_pins_oe = drive_hi_ff;
    assign alert_n = alert_n_ff;

endmodule : ipe_port_expander

// *** ipe_port_expander_properties.sv ***
`timescale 1ns/1ps
module ipe_port_expander_checker #(
    parameter logic [3:0] FIXED_ADDR = 4'h4,
    parameter int FIFO_DEPTH = 8,
    parameter int SETTLE_CYCLES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [2:0] addr_pins_i,
    input wire logic [7:0] low_port_pins_i,
    input wire logic [7:0] low_port_pins_o,
    input wire logic [7:0] low_port_pins_oe,
    input wire logic [7:0] high_port_pins_i,
    input wire logic [7:0] high_port_pins_o,
    input wire logic [7:0] high_port_pins_oe,
    input wire logic alert_n
);
    // ----------------------------------------
    // Pin quiet time and properties
    // ----------------------------------------
    logic [15:0] pins;
    logic [15:0] prev_pins_ff;
    logic [4:0] quiet_ff;
    logic [4:0] nxt_quiet;
    assign pins = {high_port_pins_i, low_port_pins_i};
    assign nxt_quiet = (pins != prev_pins_ff) ? 5'h00 :
                       (quiet_ff == 5'h1F) ? 5'h1F : quiet_ff + 5'h01;
    // Saturating count, so long idle spans never wrap back to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_pins_ff <= 16'hFFFF;
            quiet_ff <= 5'h00;
        end else begin
            prev_pins_ff <= pins;
            quiet_ff <= nxt_quiet;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence scl_high3;
        scl_i && $past(scl_i) && $past(scl_i, 2);
    endsequence
    sequence ack_hold;
        sda_oe [*8];
    endsequence
    a_reset_values: assert property (
        $rose(resetn) |-> !sda_oe && alert_n && low_port_pins_oe == 8'h00
            && high_port_pins_oe == 8'h00) else $error("outputs not idle after reset");
    a_pins_pull_low: assert property (
        sda_o == 1'b0 && low_port_pins_o == 8'h00 && high_port_pins_o == 8'h00)
        else $error("open drain value not low");
    a_port_after_ack: assert property (
        ($changed(low_port_pins_oe) || $changed(high_port_pins_oe)) |->
            sda_oe || $past(sda_oe) || $past(sda_oe, 2) || $past(sda_oe, 3))
        else $error("port changed outside an acknowledge");
    a_sda_in_low: assert property (
        $changed(sda_oe) |-> !scl_i) else $error("data line moved with clock high");
    a_drive_holds: assert property (
        $rose(sda_oe) |-> ack_hold) else $error("data line drive too short");
    a_alert_cause: assert property (
        $fell(alert_n) |-> quiet_ff <= 5'h08) else $error("alert without pin edge");
    a_alert_raise: assert property (
        $changed(pins) && scl_i && sda_i && alert_n && quiet_ff >= 5'h14 |-> ##[1:8] !alert_n)
        else $error("pin edge raised no alert");
    a_alert_holds: assert property (
        scl_high3 ##0 (!alert_n && quiet_ff >= 5'h08) |=> !alert_n)
        else $error("alert dropped without cause");
endmodule : ipe_port_expander_checker

bind ipe_port_expander ipe_port_expander_checker #(.FIXED_ADDR(FIXED_ADDR),
    .FIFO_DEPTH(FIFO_DEPTH), .SETTLE_CYCLES(SETTLE_CYCLES)) u_ipe_port_expander_checker (
    .clk(clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_pins_i(addr_pins_i), .low_port_pins_i(low_port_pins_i),
    .low_port_pins_o(low_port_pins_o), .low_port_pins_oe(low_port_pins_oe),
    .high_port_pins_i(high_port_pins_i), .high_port_pins_o(high_port_pins_o),
    .high_port_pins_oe(high_port_pins_oe), .alert_n(alert_n));

// *** ipe_i2c_master.sv ***
`timescale 1ns/1ps
module ipe_i2c_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // ----------------------------------------
    // Serial master, 160 ns clock
    // ----------------------------------------
    // Released lines; the clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic half();
        repeat (8) @(negedge clk);
    endtask : half
    // Data moves a cycle after the clock falls, so it never mimics a frame edge
    task automatic bit_io(input logic b, output logic r);
        @(negedge clk);
        sda_m = b;
        // Low phase is eight cycles in all, high phase eight more
        repeat (7) @(negedge clk);
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        @(negedge clk);
        sda_m = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_m = 1'b0;
        half();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        @(negedge clk);
        sda_m = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_m = 1'b1;
        half();
    endtask : stop
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(!ack, r);
    endtask : rd_byte
    task automatic address(input logic [6:0] a, input logic rw, output logic ack);
        start();
        wr_byte({a, rw}, ack);
    endtask : address
endmodule : ipe_i2c_master

// *** ipe_port_expander_test.sv ***
`timescale 1ns/1ps
module ipe_port_expander_test;
    localparam logic [3:0] FIX = ipe_pkg::ADDR_FIXED_RST;
    logic clk = 1'b0;
    logic resetn, scl, sda_m, sda_w, sda_o, sda_oe, alert_n, ack;
    logic [2:0] addr_pins;
    logic [7:0] low_ext, high_ext, low_o, low_oe, high_o, high_oe, low_w, high_w, rd;
    int errors;
    int tests_run;
    // ----------------------------------------
    // Clock, lines and instances
    // ----------------------------------------
    always #5 clk = ~clk;
    // Open-drain lines sit high unless a party pulls them low
    assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    assign low_w = (low_oe & low_o) | (~low_oe & low_ext);
    assign high_w = (high_oe & high_o) | (~high_oe & high_ext);
    ipe_port_expander #(.SETTLE_CYCLES(4)) u_ipe_port_expander (
        .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_pins_i(addr_pins), .low_port_pins_i(low_w),
        .low_port_pins_o(low_o), .low_port_pins_oe(low_oe), .high_port_pins_i(high_w),
        .high_port_pins_o(high_o), .high_port_pins_oe(high_oe), .alert_n(alert_n));
    ipe_i2c_master u_ipe_i2c_master (.clk(clk), .sda(sda_w), .scl(scl), .sda_m(sda_m));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic open(input logic rw);
        u_ipe_i2c_master.address({FIX, addr_pins}, rw, ack);
    endtask : open
    task automatic put(input logic [7:0] b);
        u_ipe_i2c_master.wr_byte(b, ack);
    endtask : put
    task automatic get(input logic more);
        u_ipe_i2c_master.rd_byte(rd, more);
    endtask : get
    // Bounded wait; the alert is registered a few cycles behind the pins
    task automatic wait_alert(input logic lvl);
        for (int i = 0; i < 20 && alert_n !== lvl; i++) begin
            @(negedge clk);
        end
    endtask : wait_alert
    task automatic t_reset();
        check({low_oe, high_oe}, 16'h0000);
        check(alert_n, 1'b1);
        open(1'b1);
        check(ack, 1'b1);
        get(1'b1);
        check(rd, 8'hFF);
        get(1'b0);
        check(rd, 8'hFF);
        u_ipe_i2c_master.stop();
    endtask : t_reset
    // Three bytes in one transfer: low, high, then low again
    task automatic t_write();
        open(1'b0);
        put(8'hFB);
        check({low_oe, high_oe}, 16'h0400);
        put(8'h0F);
        check({low_oe, high_oe}, 16'h04F0);
        put(8'hF3);
        check({low_oe, high_oe}, 16'h0CF0);
        check(ack, 1'b1);
        u_ipe_i2c_master.stop();
    endtask : t_write
    task automatic t_read();
        low_ext = 8'hFD;
        wait_alert(1'b0);
        check(alert_n, 1'b0);
        open(1'b1);
        get(1'b1);
        check(rd, 8'hF1);
        low_ext = 8'hFF;
        get(1'b1);
        check(rd, 8'h0F);
        get(1'b0);
        check(rd, 8'hF3);
        u_ipe_i2c_master.stop();
    endtask : t_read
    // High alert pending, low pin moves between the two read bytes
    task automatic t_split();
        high_ext = 8'hFE;
        wait_alert(1'b0);
        check(alert_n, 1'b0);
        open(1'b1);
        get(1'b1);
        check(alert_n, 1'b0);
        low_ext = 8'hFD;
        get(1'b0);
        check(rd, 8'h0E);
        u_ipe_i2c_master.stop();
        check(alert_n, 1'b0);
        open(1'b1);
        get(1'b0);
        u_ipe_i2c_master.stop();
        check(alert_n, 1'b1);
    endtask : t_split
    task automatic t_withdraw();
        low_ext = 8'hFF;
        wait_alert(1'b0);
        check(alert_n, 1'b0);
        low_ext = 8'hFD;
        wait_alert(1'b1);
        check(alert_n, 1'b1);
    endtask : t_withdraw
    // A single low byte clears a high-port alert
    task automatic t_wr_clear();
        high_ext = 8'hFF;
        wait_alert(1'b0);
        check(alert_n, 1'b0);
        open(1'b0);
        put(8'hF3);
        u_ipe_i2c_master.stop();
        check(alert_n, 1'b1);
        check({low_oe, high_oe}, 16'h0CF0);
    endtask : t_wr_clear
    task automatic t_addr();
        u_ipe_i2c_master.address({FIX, 3'h2}, 1'b0, ack);
        check(ack, 1'b0);
        u_ipe_i2c_master.stop();
        addr_pins = 3'h2;
        open(1'b0);
        check(ack, 1'b1);
        put(8'hFF);
        u_ipe_i2c_master.stop();
        check({low_oe, high_oe}, 16'h00F0);
    endtask : t_addr
    // Main sequence, inputs move on falling edges
    initial begin
        errors = 0;
        tests_run = 0;
        resetn = 1'b0;
        addr_pins = 3'h5;
        low_ext = 8'hFF;
        high_ext = 8'hFF;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_write();
        t_read();
        t_split();
        t_withdraw();
        t_wr_clear();
        t_addr();
        results();
    end
    // Watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end
endmodule : ipe_port_expander_test
